// ### rsr_defs.svh
`ifndef RSR_DEFS_SVH
`define RSR_DEFS_SVH

// ----------------------------------------------------------------------
// register map
// ----------------------------------------------------------------------
`define RSR_AW             12
`define RSR_DW             8
`define RSR_REG_WDCTL      12'hFF0
`define RSR_REG_WAKE       12'hFF4

// ----------------------------------------------------------------------
// cause flag field: bits 7:4 of the watchdog control register
// ----------------------------------------------------------------------
`define RSR_FLAG_LSB       4
`define RSR_FLAG_POR       3
`define RSR_FLAG_STOP      2
`define RSR_FLAG_WDT       1
`define RSR_FLAG_EXT       0
`define RSR_FLAGS_RST      4'h8
`define RSR_WAKE_RST       8'h00
`define RSR_DBG_RST_BIT    1

// ----------------------------------------------------------------------
// sequence counts and reset vector
// ----------------------------------------------------------------------
`define RSR_SYS_WDT_CYC    514
`define RSR_SHORT_WDT_CYC  66
`define RSR_CLK_CYC        16
`define RSR_VEC_ADDR_HI    16'h0002

`endif

// ### rsr_pkg.sv
package rsr_pkg;

    // ------------------------------------------------------------------
    // sequencer states and reset kinds
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        RSR_ST_IDLE = 2'b00,
        RSR_ST_WDT  = 2'b01,
        RSR_ST_CLK  = 2'b10,
        RSR_ST_HOLD = 2'b11
    } rsr_state_t;

    typedef enum logic [1:0] {
        RSR_K_SYSTEM = 2'b00,
        RSR_K_SHORT  = 2'b01,
        RSR_K_SMR    = 2'b10
    } rsr_kind_t;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       por_detect;
        logic       brownout_detect;
        logic       wdt_timeout;
        logic       ext_reset_n;
        logic       debug_pin_n;
        logic [7:0] debugger_control_reg;
    } rsr_src_t;

    typedef struct packed {
        logic       valid;
        rsr_kind_t  kind;
        logic       spare_dbg;
        logic [3:0] cause;
    } rsr_req_t;

    typedef struct packed {
        logic core_rst;
        logic periph_rst;
        logic dbg_rst;
        logic sys_clk_en;
        logic xtal_run;
        logic wdt_osc_run;
        logic ctl_load;
        logic vec_fetch;
    } rsr_hold_t;

endpackage : rsr_pkg

// ### rsr_wake_detect.sv
`timescale 1ns/1ps
`default_nettype none

module rsr_wake_detect #(
    parameter int WAKE_W = 8
) (
    input  wire logic              sys_clk,
    input  wire logic              nrst,
    input  wire logic [WAKE_W-1:0] pins,
    input  wire logic [WAKE_W-1:0] mask,
    input  wire logic              arm,
    output logic                   wake
);
    logic [WAKE_W-1:0] pin_q_r;
    logic [WAKE_W-1:0] change;
    logic              wake_r;

    // ------------------------------------------------------------------
    // per pin transition detect
    // ------------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < WAKE_W; i = i + 1) begin : g_pin
            always_ff @(posedge sys_clk or negedge nrst) begin
                if (!nrst) begin
                    pin_q_r[i] <= 1'b0;
                end else begin
                    pin_q_r[i] <= pins[i];
                end
            end
            assign change[i] = (pins[i] ^ pin_q_r[i]) & mask[i];
        end
    endgenerate

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            wake_r <= 1'b0;
        end else begin
            wake_r <= arm & (|change);
        end
    end

    assign wake = wake_r;

endmodule : rsr_wake_detect

`default_nettype wire

// ### rsr_sequencer.sv
// Function
// RQ1 - normal mode: por, brownout, watchdog, pin, debugger
// RQ2 - stop mode: watchdog, wake pin, debug pin recover
// RQ3 - system reset: 514 oscillator plus 16 clocks
// RQ4 - short reset: only 66 oscillator cycles differ
// RQ5 - stop recovery: 514 plus 16, registers kept
// RQ6 - reset type from mode and source
// RQ7 - hold core idle, both oscillators running
// RQ8 - system clock starts after oscillator count
// RQ9 - load defined reset values, rest undefined
// RQ10 - core fetches vector at 0002H/0003H
// RQ11 - power-on and brownout win over all; brownout is ignored in stop mode
// RQ12 - source to type mapping per mode
// RQ13 - held pin keeps reset, release exits
// RQ14 - set cause flag after each reset; debugger and debug pin resets set none
// RQ15 - new request restarts, highest priority type
`include "rsr_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module rsr_sequencer #(
    parameter int         WAKE_W        = 8,
    parameter int         CW            = 10,
    parameter int         SYS_WDT_CYC   = `RSR_SYS_WDT_CYC,
    parameter int         SHORT_WDT_CYC = `RSR_SHORT_WDT_CYC,
    parameter int         CLK_CYC       = `RSR_CLK_CYC
) (
    input  wire logic                sys_clk,
    input  wire logic                nrst,
    input  wire logic [`RSR_AW-1:0]  addr,
    input  wire logic [`RSR_DW-1:0]  wdata,
    input  wire logic                wr,
    input  wire logic                rd,
    output logic      [`RSR_DW-1:0]  rdata,
    input  wire rsr_pkg::rsr_src_t   src,
    input  wire logic                wdt_osc,
    input  wire logic                stop_mode,
    input  wire logic                watchdog_reset_select_option,
    input  wire logic [WAKE_W-1:0]   wake_pins,
    output rsr_pkg::rsr_hold_t       hold,
    output logic      [15:0]         vec_addr
);
    import rsr_pkg::*;

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    rsr_state_t        state_r;
    rsr_state_t        state_nxt;
    rsr_kind_t         kind_r;
    rsr_kind_t         kind_nxt;
    logic              spare_r;
    logic              spare_nxt;
    logic [CW-1:0]     wcnt_r;
    logic [CW-1:0]     wcnt_nxt;
    logic [4:0]        ccnt_r;
    logic [4:0]        ccnt_nxt;
    logic [CW-1:0]     wdt_last;
    logic              wdt_osc_q_r;
    logic              osc_tick;
    logic              pin_q_r;
    logic              dpin_q_r;
    logic              dbit_q_r;
    logic              pin_fall;
    logic              dpin_fall;
    logic              dbit_rise;
    logic              wake;
    logic [WAKE_W-1:0] wake_mask_r;
    logic [3:0]        flags_r;
    logic [`RSR_DW-1:0] rdata_r;
    rsr_hold_t         hold_r;
    logic [15:0]       vec_addr_r;
    rsr_req_t          req;

    localparam logic [CW-1:0] SYS_LAST   = CW'(SYS_WDT_CYC - 1);
    localparam logic [CW-1:0] SHORT_LAST = CW'(SHORT_WDT_CYC - 1);
    localparam logic [4:0]    CLK_LAST   = 5'(CLK_CYC - 1);

    // ------------------------------------------------------------------
    // functions
    // ------------------------------------------------------------------
    function automatic logic hit(input logic [`RSR_AW-1:0] a,
                                 input logic [`RSR_AW-1:0] off);
        hit = (a == off);
    endfunction : hit

    function automatic rsr_req_t decode(input logic por,
                                        input logic bo,
                                        input logic stop,
                                        input logic wdt_to,
                                        input logic opt,
                                        input logic pfall,
                                        input logic dfall,
                                        input logic drise,
                                        input logic wk);
        rsr_req_t r;
        r.valid     = 1'b0;
        r.kind      = RSR_K_SYSTEM;
        r.spare_dbg = 1'b0;
        r.cause     = 4'h0;
        // RQ11 power first
        if (por || (bo && !stop)) begin
            r.valid = 1'b1;
            r.cause[`RSR_FLAG_POR] = 1'b1;
        end else if (stop) begin
            // RQ2 stop mode sources
            // RQ12 stop mode mapping
            if (pfall) begin
                r.valid = 1'b1;
                r.cause[`RSR_FLAG_EXT] = 1'b1;
            end else if (dfall) begin
                r.valid = 1'b1;
            end else if (wdt_to) begin
                r.valid = 1'b1;
                r.kind  = RSR_K_SMR;
                r.cause[`RSR_FLAG_WDT]  = 1'b1;
                r.cause[`RSR_FLAG_STOP] = 1'b1;
            end else if (wk) begin
                r.valid = 1'b1;
                r.kind  = RSR_K_SMR;
                r.cause[`RSR_FLAG_STOP] = 1'b1;
            end
        end else begin
            // RQ1 normal mode sources
            // RQ12 normal mode mapping
            if (drise) begin
                r.valid     = 1'b1;
                r.spare_dbg = 1'b1;
            end else if (pfall) begin
                r.valid = 1'b1;
                r.kind  = RSR_K_SHORT;
                r.cause[`RSR_FLAG_EXT] = 1'b1;
            end else if (wdt_to && opt) begin
                r.valid = 1'b1;
                r.kind  = RSR_K_SHORT;
                r.cause[`RSR_FLAG_WDT] = 1'b1;
            end
        end
        decode = r;
    endfunction : decode

    // ------------------------------------------------------------------
    // source edges
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            wdt_osc_q_r <= 1'b0;
            pin_q_r     <= 1'b1;
            dpin_q_r    <= 1'b1;
            dbit_q_r    <= 1'b0;
        end else begin
            wdt_osc_q_r <= wdt_osc;
            pin_q_r     <= src.ext_reset_n;
            dpin_q_r    <= src.debug_pin_n;
            dbit_q_r    <= src.debugger_control_reg[`RSR_DBG_RST_BIT];
        end
    end

    assign osc_tick  = wdt_osc & ~wdt_osc_q_r;
    assign pin_fall  = pin_q_r & ~src.ext_reset_n;
    assign dpin_fall = dpin_q_r & ~src.debug_pin_n;
    assign dbit_rise = src.debugger_control_reg[`RSR_DBG_RST_BIT] & ~dbit_q_r;

    rsr_wake_detect #(
        .WAKE_W (WAKE_W)
    ) u_wake (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .pins    (wake_pins),
        .mask    (wake_mask_r),
        .arm     (stop_mode),
        .wake    (wake)
    );

    // RQ6 type from mode and source
    assign req = decode(src.por_detect, src.brownout_detect, stop_mode,
                        src.wdt_timeout, watchdog_reset_select_option,
                        pin_fall, dpin_fall, dbit_rise, wake);

    // ------------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------------
    // RQ4 short count
    assign wdt_last = (kind_r == RSR_K_SHORT) ? SHORT_LAST : SYS_LAST;

    always_comb begin
        state_nxt = state_r;
        kind_nxt  = kind_r;
        spare_nxt = spare_r;
        wcnt_nxt  = wcnt_r;
        ccnt_nxt  = ccnt_r;
        // RQ15 restart on request
        if (req.valid) begin
            state_nxt = RSR_ST_WDT;
            kind_nxt  = req.kind;
            spare_nxt = req.spare_dbg;
            wcnt_nxt  = '0;
            ccnt_nxt  = '0;
        end else begin
            unique case (state_r)
                RSR_ST_IDLE: begin
                    state_nxt = RSR_ST_IDLE;
                end
                // RQ3 oscillator count
                RSR_ST_WDT: begin
                    if (osc_tick) begin
                        if (wcnt_r == wdt_last) begin
                            state_nxt = RSR_ST_CLK;
                            ccnt_nxt  = '0;
                        end else begin
                            wcnt_nxt = wcnt_r + 1'b1;
                        end
                    end
                end
                // RQ8 sixteen clock tail
                RSR_ST_CLK: begin
                    if (ccnt_r == CLK_LAST) begin
                        state_nxt = src.ext_reset_n ? RSR_ST_IDLE
                                                    : RSR_ST_HOLD;
                    end else begin
                        ccnt_nxt = ccnt_r + 1'b1;
                    end
                end
                // RQ13 held pin release
                RSR_ST_HOLD: begin
                    if (src.ext_reset_n) begin
                        state_nxt = RSR_ST_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state_r <= RSR_ST_WDT;
            kind_r  <= RSR_K_SYSTEM;
            spare_r <= 1'b0;
            wcnt_r  <= '0;
            ccnt_r  <= '0;
        end else begin
            state_r <= state_nxt;
            kind_r  <= kind_nxt;
            spare_r <= spare_nxt;
            wcnt_r  <= wcnt_nxt;
            ccnt_r  <= ccnt_nxt;
        end
    end

    // ------------------------------------------------------------------
    // hold outputs
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            hold_r.core_rst    <= 1'b1;
            hold_r.periph_rst  <= 1'b1;
            hold_r.dbg_rst     <= 1'b1;
            hold_r.sys_clk_en  <= 1'b0;
            hold_r.xtal_run    <= 1'b1;
            hold_r.wdt_osc_run <= 1'b1;
            hold_r.ctl_load    <= 1'b1;
            hold_r.vec_fetch   <= 1'b0;
        end else begin
            // RQ7 core held idle
            hold_r.core_rst    <= (state_nxt != RSR_ST_IDLE);
            // RQ5 recovery spares peripherals
            hold_r.periph_rst  <= (state_nxt != RSR_ST_IDLE) &&
                                  (kind_nxt != RSR_K_SMR);
            hold_r.dbg_rst     <= (state_nxt != RSR_ST_IDLE) &&
                                  (kind_nxt != RSR_K_SMR) && !spare_nxt;
            // RQ8 clock after count
            hold_r.sys_clk_en  <= (state_nxt != RSR_ST_WDT);
            // RQ7 oscillators keep running
            hold_r.xtal_run    <= 1'b1;
            hold_r.wdt_osc_run <= 1'b1;
            // RQ9 reset value load
            hold_r.ctl_load    <= req.valid && (req.kind != RSR_K_SMR);
            // RQ10 vector fetch on release
            hold_r.vec_fetch   <= (state_r != RSR_ST_IDLE) &&
                                  (state_nxt == RSR_ST_IDLE);
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            vec_addr_r <= `RSR_VEC_ADDR_HI;
        end else if ((state_r != RSR_ST_IDLE) &&
                     (state_nxt == RSR_ST_IDLE)) begin
            vec_addr_r <= `RSR_VEC_ADDR_HI;
        end
    end

    assign hold     = hold_r;
    assign vec_addr = vec_addr_r;

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            flags_r <= `RSR_FLAGS_RST;
        end else if (req.valid) begin
            // RQ14 cause flags
            flags_r <= (req.kind == RSR_K_SMR) ? (flags_r | req.cause)
                                               : req.cause;
        end else if (wr && hit(addr, `RSR_REG_WDCTL)) begin
            flags_r <= flags_r & ~wdata[`RSR_DW-1:`RSR_FLAG_LSB];
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            wake_mask_r <= WAKE_W'(`RSR_WAKE_RST);
        // RQ9 load reset value
        end else if (req.valid && (req.kind != RSR_K_SMR)) begin
            wake_mask_r <= WAKE_W'(`RSR_WAKE_RST);
        end else if (wr && hit(addr, `RSR_REG_WAKE)) begin
            wake_mask_r <= WAKE_W'(wdata);
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rdata_r <= '0;
        end else if (rd && hit(addr, `RSR_REG_WDCTL)) begin
            rdata_r <= {flags_r, 4'h0};
        end else if (rd && hit(addr, `RSR_REG_WAKE)) begin
            rdata_r <= `RSR_DW'(wake_mask_r);
        end else begin
            rdata_r <= '0;
        end
    end

    assign rdata = rdata_r;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    // RQ7 core held
    a_core_held_idle: assert property (@(posedge sys_clk) disable iff (!nrst)
        (state_r != RSR_ST_IDLE) |-> (hold_r.core_rst && hold_r.xtal_run &&
                                      hold_r.wdt_osc_run)) // RQ7
        else $error("core not held during reset");

    // RQ8 clock gated
    a_clk_after_count: assert property (@(posedge sys_clk) disable iff (!nrst)
        (state_r == RSR_ST_WDT) |-> !hold_r.sys_clk_en) // RQ8
        else $error("system clock enabled during oscillator count");

    // RQ3 system count
    a_sys_osc_len: assert property (@(posedge sys_clk) disable iff (!nrst)
        (state_r == RSR_ST_WDT && state_nxt == RSR_ST_CLK &&
         kind_r != RSR_K_SHORT) |-> (wcnt_r == 10'd513)) // RQ3
        else $error("system oscillator count wrong");

    // RQ4 short count
    a_short_osc_len: assert property (@(posedge sys_clk) disable iff (!nrst)
        (state_r == RSR_ST_WDT && state_nxt == RSR_ST_CLK &&
         kind_r == RSR_K_SHORT) |-> (wcnt_r == 10'd65)) // RQ4
        else $error("short oscillator count wrong");

    // RQ8 clock tail length
    a_clk_tail_len: assert property (@(posedge sys_clk) disable iff (!nrst)
        (state_r == RSR_ST_CLK && state_nxt != RSR_ST_CLK && !req.valid)
        |-> (ccnt_r == 5'd15)) // RQ8
        else $error("clock tail not sixteen cycles");

    // RQ5 recovery spares
    a_smr_spares_regs: assert property (@(posedge sys_clk) disable iff (!nrst)
        (req.valid && req.kind == RSR_K_SMR) |=>
        (!hold_r.periph_rst && !hold_r.ctl_load &&
         $stable(wake_mask_r))) // RQ5
        else $error("stop recovery disturbed registers");

    // RQ11 power priority
    a_por_priority: assert property (@(posedge sys_clk) disable iff (!nrst)
        src.por_detect |=> (kind_r == RSR_K_SYSTEM &&
                            state_r == RSR_ST_WDT && wcnt_r == '0)) // RQ11
        else $error("power-on did not force system reset");

    // RQ14 flags
    a_cause_flag_set: assert property (@(posedge sys_clk) disable iff (!nrst)
        req.valid |=> ((flags_r & $past(req.cause)) ==
                       $past(req.cause))) // RQ14
        else $error("cause flag not set");

    // RQ13 pin release
    a_pin_release: assert property (@(posedge sys_clk) disable iff (!nrst)
        (state_r == RSR_ST_HOLD && src.ext_reset_n && !req.valid)
        |=> (state_r == RSR_ST_IDLE) ##1 !hold_r.core_rst) // RQ13
        else $error("held pin release did not exit");

    // RQ12 normal pin short
    a_pin_short: assert property (@(posedge sys_clk) disable iff (!nrst)
        (pin_fall && !stop_mode && !src.por_detect &&
         !src.brownout_detect && !dbit_rise) |=>
        (kind_r == RSR_K_SHORT)) // RQ12
        else $error("pin reset not short in normal mode");

    // RQ10 vector fetch
    a_vec_on_release: assert property (@(posedge sys_clk) disable iff (!nrst)
        $fell(hold_r.core_rst) |-> (hold_r.vec_fetch &&
                                    vec_addr_r == 16'h0002)) // RQ10
        else $error("no vector fetch at release");

endmodule : rsr_sequencer

`default_nettype wire

// ### rsr_core_model.sv
`timescale 1ns/1ps
`default_nettype none

// --------------------------------------------------------------
// core held by the sequencer; peripherals not modelled
// --------------------------------------------------------------
module rsr_core_model
    import rsr_pkg::*;
(
    input  wire logic               sys_clk,
    input  wire logic               nrst,
    input  wire rsr_pkg::rsr_hold_t hold,
    input  wire logic [15:0]        vec_addr,
    output logic      [15:0]        fetch_addr,
    output logic      [7:0]         fetch_cnt,
    output logic                    ran_in_reset
);
    logic core_q_r;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            core_q_r     <= 1'b1;
            ran_in_reset <= 1'b0;
        end else begin
            core_q_r <= hold.core_rst;
            if ((hold.vec_fetch != (core_q_r && !hold.core_rst)) ||
                (!hold.core_rst && !hold.sys_clk_en)) begin
                ran_in_reset <= 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            fetch_addr <= 16'hFFFF;
            fetch_cnt  <= 8'h00;
        end else if (hold.vec_fetch) begin
            fetch_addr <= vec_addr;
            fetch_cnt  <= fetch_cnt + 8'h01;
        end
    end
endmodule : rsr_core_model

`default_nettype wire

// ### reset_and_stop_recovery_sequencer_tb.sv
`include "rsr_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module reset_and_stop_recovery_sequencer_tb;
    import rsr_pkg::*;
    localparam int SYS = `RSR_SYS_WDT_CYC;
    localparam int SHT = `RSR_SHORT_WDT_CYC;
    logic              sys_clk = 1'b0;
    logic              nrst    = 1'b0;
    logic [11:0]       addr    = 12'h000;
    logic [7:0]        wdata   = 8'h00;
    logic              wr      = 1'b0;
    logic              rd      = 1'b0;
    logic [7:0]        rdata;
    rsr_src_t          src     = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 8'h00};
    logic              wdt_osc = 1'b0;
    logic              stop_mode = 1'b0;
    logic              opt     = 1'b1;
    logic [7:0]        wake_pins = 8'h00;
    rsr_hold_t         hold;
    logic [15:0]       vec_addr;
    logic [15:0]       fetch_addr;
    logic [7:0]        fetch_cnt;
    logic              ran_in_reset;
    logic [1:0]        div     = 2'b00;
    logic [7:0]        v;
    int                n_mismatch = 0;
    int                total_checks = 0;

    always #25 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        div <= (div == 2'd2) ? 2'd0 : div + 2'd1;
        if (div == 2'd2) wdt_osc <= ~wdt_osc;
    end

    rsr_sequencer i_dut (.sys_clk(sys_clk), .nrst(nrst), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .src(src),
        .wdt_osc(wdt_osc), .stop_mode(stop_mode),
        .watchdog_reset_select_option(opt), .wake_pins(wake_pins),
        .hold(hold), .vec_addr(vec_addr));
    rsr_core_model i_core (.sys_clk(sys_clk), .nrst(nrst), .hold(hold),
        .vec_addr(vec_addr), .fetch_addr(fetch_addr),
        .fetch_cnt(fetch_cnt), .ran_in_reset(ran_in_reset));

    // ----------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge sys_clk);
        wr    <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [11:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge sys_clk);
        rd   <= 1'b0;
        #1 d = rdata;
    endtask : rd_reg

    task automatic run_seq(input int eo, input logic per, input logic dbg);
        int   osc, clk, n;
        logic prev, sp, sd, sl;
        logic [7:0] f0;
        osc = 0;
        clk = 0;
        n = 0;
        sp = 1'b0;
        sd = 1'b0;
        sl = 1'b0;
        prev = wdt_osc;
        f0 = fetch_cnt;
        @(negedge sys_clk);
        while (hold.core_rst !== 1'b1 && n < 8) begin
            prev = wdt_osc;
            @(negedge sys_clk);
            n++;
        end
        while (hold.core_rst === 1'b1 && n < 8000) begin
            if (!hold.sys_clk_en && wdt_osc && !prev) osc++;
            if (hold.sys_clk_en === 1'b1) clk++;
            sp = sp | hold.periph_rst;
            sd = sd | hold.dbg_rst;
            sl = sl | hold.ctl_load;
            prev = wdt_osc;
            @(negedge sys_clk);
            n++;
        end
        check(16'(osc), 16'(eo));
        check(16'(clk), 16'(`RSR_CLK_CYC));
        check({15'h0, sp}, {15'h0, per});
        check({15'h0, sd}, {15'h0, dbg});
        check({15'h0, sl}, {15'h0, per});
        check(16'({hold.xtal_run, hold.wdt_osc_run}), 16'h0003);
        @(negedge sys_clk);
        check(fetch_addr, 16'h0002);
        check({8'h00, fetch_cnt}, {8'h00, f0 + 8'h01});
    endtask : run_seq

    task automatic results;
        $display("mismatches=%0d checks=%0d", n_mismatch, total_checks);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : results

    // ----------------------------------------------------------
    // tests
    // ----------------------------------------------------------
    initial begin
        repeat (12) @(posedge sys_clk);
        nrst <= 1'b1;
        run_seq(SYS, 1'b1, 1'b1);
        rd_reg(12'hFF0, v); check(16'(v), 16'h0080);
        rd_reg(12'hFFF, v); check(16'(v), 16'h0000);
        wr_reg(12'hFF0, 8'hF0);
        wr_reg(12'hFF4, 8'h01);
        rd_reg(12'hFF0, v); check(16'(v), 16'h0000);
        rd_reg(12'hFF4, v); check(16'(v), 16'h0001);
        @(posedge sys_clk) src.ext_reset_n <= 1'b0;
        @(posedge sys_clk) src.ext_reset_n <= 1'b1;
        run_seq(SHT, 1'b1, 1'b1);
        rd_reg(12'hFF0, v); check(16'(v), 16'h0010);
        rd_reg(12'hFF4, v); check(16'(v), 16'h0000);
        opt <= 1'b0;
        @(posedge sys_clk) src.wdt_timeout <= 1'b1;
        @(posedge sys_clk) src.wdt_timeout <= 1'b0;
        repeat (4) @(posedge sys_clk);
        #1 check({15'h0, hold.core_rst}, 16'h0000);
        opt <= 1'b1;
        @(posedge sys_clk) src.wdt_timeout <= 1'b1;
        @(posedge sys_clk) src.wdt_timeout <= 1'b0;
        run_seq(SHT, 1'b1, 1'b1);
        rd_reg(12'hFF0, v); check(16'(v), 16'h0020);
        @(posedge sys_clk) src.debugger_control_reg <= 8'h02;
        run_seq(SYS, 1'b1, 1'b0);
        @(posedge sys_clk) src.debugger_control_reg <= 8'h00;
        src.ext_reset_n <= 1'b0;
        repeat (100) @(posedge sys_clk);
        src.por_detect <= 1'b1;
        @(posedge sys_clk) src.por_detect <= 1'b0;
        src.ext_reset_n <= 1'b1;
        run_seq(SYS, 1'b1, 1'b1);
        wr_reg(12'hFF0, 8'hF0);
        wr_reg(12'hFF4, 8'h01);
        @(posedge sys_clk) stop_mode <= 1'b1;
        @(posedge sys_clk) wake_pins <= 8'h01;
        run_seq(SYS, 1'b0, 1'b0);
        stop_mode <= 1'b0;
        rd_reg(12'hFF0, v); check(16'(v), 16'h0040);
        rd_reg(12'hFF4, v); check(16'(v), 16'h0001);
        @(posedge sys_clk) src.ext_reset_n <= 1'b0;
        repeat (700) @(posedge sys_clk);
        #1 check({15'h0, hold.core_rst}, 16'h0001);
        @(posedge sys_clk) src.ext_reset_n <= 1'b1;
        repeat (2) @(posedge sys_clk);
        #1 check({15'h0, hold.core_rst}, 16'h0000);
        @(posedge sys_clk) stop_mode <= 1'b1;
        @(posedge sys_clk) src.debug_pin_n <= 1'b0;
        run_seq(SYS, 1'b1, 1'b1);
        rd_reg(12'hFF0, v); check(16'(v), 16'h0000);
        @(posedge sys_clk) src.debug_pin_n <= 1'b1;
        opt <= 1'b0;
        @(posedge sys_clk) src.wdt_timeout <= 1'b1;
        @(posedge sys_clk) src.wdt_timeout <= 1'b0;
        run_seq(SYS, 1'b0, 1'b0);
        rd_reg(12'hFF0, v); check(16'(v), 16'h0060);
        check({15'h0, ran_in_reset}, 16'h0000);
        results();
    end

    initial begin
        #(50 * 60000);
        n_mismatch++;
        results();
    end
endmodule : reset_and_stop_recovery_sequencer_tb

`default_nettype wire
